// ---- rtl/pspi_pkg.sv ----
package pspi_pkg;

  localparam int unsigned ADDR_W          = 8;
  localparam int unsigned DATA_W          = 32;
  localparam int unsigned N_DIG           = 3;
  localparam int unsigned N_ANA           = 3;

  localparam logic [7:0]  ADDR_CTRL       = 8'h00;
  localparam logic [7:0]  ADDR_TRIP_CFG   = 8'h04;
  localparam logic [7:0]  ADDR_PASSIVE    = 8'h08;
  localparam logic [7:0]  ADDR_STATUS     = 8'h0C;

  localparam int unsigned CTRL_PRESENT    = 0;
  localparam int unsigned CTRL_GPIO_CFG   = 1;
  localparam int unsigned CTRL_POL_HIGH   = 2;
  localparam int unsigned CTRL_SAFE_FLOAT = 3;
  localparam int unsigned CTRL_W          = 4;
  localparam logic [3:0]  CTRL_RESET      = 4'h5;

  localparam int unsigned TCFG_ANA_LSB    = 6;
  localparam int unsigned TCFG_W          = 9;
  localparam logic [8:0]  TCFG_RESET      = 9'h000;

  localparam int unsigned ST_RUN          = 0;
  localparam int unsigned ST_SETTLE       = 1;
  localparam int unsigned ST_OS_LSB       = 2;
  localparam int unsigned ST_CBC_LSB      = 5;
  localparam int unsigned ST_ANA_LSB      = 8;

  localparam logic [1:0]  REACT_NONE      = 2'h0;
  localparam logic [1:0]  REACT_ONESHOT   = 2'h1;
  localparam logic [1:0]  REACT_CBC       = 2'h2;

  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned SETTLE_TIME_MS  = 100;
  localparam int unsigned SETTLE_CYCLES   = CLK_HZ / 1000 * SETTLE_TIME_MS;

  typedef enum logic [1:0] {
    PSPI_OFF,
    PSPI_SETTLE,
    PSPI_RUN
  } pspi_state_t;

endpackage

// ---- rtl/pspi_trip_if.sv ----
`timescale 1ns/10ps
interface pspi_trip_if;
  logic [2:0] trip_n;
  logic [2:0] ana;
  logic       underflow;
  logic       rearm;
  logic [5:0] dig_react;
  logic [2:0] ana_react;
  logic [2:0] os_latch;
  logic [2:0] cbc_latch;
  logic [2:0] ana_latch;

  modport ctl  (output trip_n, ana, underflow, rearm, dig_react, ana_react,
                input  os_latch, cbc_latch, ana_latch);
  modport unit (input  trip_n, ana, underflow, rearm, dig_react, ana_react,
                output os_latch, cbc_latch, ana_latch);
endinterface

// ---- rtl/pspi_trip_unit.sv ----
`timescale 1ns/10ps
module pspi_trip_unit
  import pspi_pkg::*;
(
  input  wire logic  i_clk,
  input  wire logic  i_rstn,
  pspi_trip_if.unit  trip
);

  genvar g;

  generate
    for (g = 0; g < N_DIG; g++)
    begin : g_dig
      logic [1:0] react;
      logic       hit;
      assign react = trip.dig_react[2*g +: 2];
      assign hit   = ~trip.trip_n[g];

      // A one-shot trip holds until the interlock is re-armed; a new hit wins.
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          trip.os_latch[g] <= 1'b0;
        else if (hit && react == REACT_ONESHOT)
          trip.os_latch[g] <= 1'b1;
        else if (trip.rearm)
          trip.os_latch[g] <= 1'b0;
      end

      // Release comes at underflow, or once the reaction is no longer REACT_CBC, so a short glitch still holds until the next underflow.
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          trip.cbc_latch[g] <= 1'b0;
        else if (hit && react == REACT_CBC)
          trip.cbc_latch[g] <= 1'b1;
        else if (trip.underflow || react != REACT_CBC)
          trip.cbc_latch[g] <= 1'b0;
      end
    end

    for (g = 0; g < N_ANA; g++)
    begin : g_ana
      always_ff @(posedge i_clk or negedge i_rstn)
      begin
        if (!i_rstn)
          trip.ana_latch[g] <= 1'b0;
        else if (trip.ana[g] && trip.ana_react[g])
          trip.ana_latch[g] <= 1'b1;
        else if (trip.rearm)
          trip.ana_latch[g] <= 1'b0;
      end
    end
  endgenerate

endmodule

// ---- rtl/pspi_top.sv ----
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/10ps
module pspi_top
  import pspi_pkg::*;
#(
  parameter int unsigned N_PWM         = 6,
  parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RSTN,
  input  wire logic              I_EN_REQ,
  input  wire logic [N_PWM-1:0]  I_PWM,
  input  wire logic              I_PWM_UNDERFLOW,
  input  wire logic              I_TRIP_ZONE_INPUT_1_N,
  input  wire logic              I_TRIP_ZONE_INPUT_2_N,
  input  wire logic              I_TRIP_ZONE_INPUT_3_N,
  input  wire logic [2:0]        I_ANALOG_TRIP,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [DATA_W-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  output logic      [DATA_W-1:0] O_RDATA,
  output logic      [N_PWM-1:0]  O_PWM,
  output logic      [N_PWM-1:0]  O_PWM_OE,
  output logic                   O_STATUS,
  output logic                   O_GATE_EN,
  output logic                   O_GATE_EN_OE
);

  // Refuse settings that would make fields overlap or fall off the bus, mismatch the trip or address widths, or leave no settle time.
  generate
    if (N_PWM < 1 || N_PWM > DATA_W)
    begin : g_bad_width
      $error("N_PWM must lie between 1 and the data width.");
    end
    if (SETTLE_CYCLES_P < 1)
    begin : g_bad_settle
      $error("SETTLE_CYCLES_P must be at least one.");
    end
    if (N_DIG != $bits({I_TRIP_ZONE_INPUT_1_N, I_TRIP_ZONE_INPUT_2_N, I_TRIP_ZONE_INPUT_3_N}))
    begin : g_bad_dig
      $error("N_DIG must match the trip-zone pins.");
    end
    if (N_ANA != $bits(I_ANALOG_TRIP))
    begin : g_bad_ana
      $error("N_ANA must match the analog trip port.");
    end
    if (TCFG_ANA_LSB != 2 * N_DIG || TCFG_W != TCFG_ANA_LSB + N_ANA)
    begin : g_bad_tcfg
      $error("Trip configuration fields do not tile the register.");
    end
    if (ST_CBC_LSB != ST_OS_LSB + N_DIG || ST_ANA_LSB != ST_CBC_LSB + N_DIG)
    begin : g_bad_status
      $error("Status register fields overlap.");
    end
    if (ST_ANA_LSB + N_ANA > DATA_W || TCFG_W > DATA_W || CTRL_W > DATA_W)
    begin : g_bad_fields
      $error("A register field lies beyond the data width.");
    end
    if (ADDR_W != $bits(ADDR_STATUS))
    begin : g_bad_addr
      $error("ADDR_W must match the register address constants.");
    end
  endgenerate

  pspi_trip_if trip ();

  pspi_state_t      state;
  pspi_state_t      next_state;
  logic [31:0]      settle_cnt;
  logic             en_prev;
  logic             en_rise;
  logic [CTRL_W-1:0] ctrl;
  logic [TCFG_W-1:0] trip_cfg;
  logic [N_PWM-1:0] passive;
  logic             next_run;
  logic             tripped;
  logic             wr_ctrl;
  logic             wr_tcfg;
  logic             wr_pass;
  logic [DATA_W-1:0] rd_value;

  assign en_rise = I_EN_REQ & ~en_prev;

  assign wr_ctrl = I_WR && I_ADDR == ADDR_CTRL;
  assign wr_tcfg = I_WR && I_ADDR == ADDR_TRIP_CFG;
  assign wr_pass = I_WR && I_ADDR == ADDR_PASSIVE;

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      en_prev <= 1'b1;
    else
      en_prev <= I_EN_REQ;
  end

  // The edge detector starts as if the request were already high, so a request
  // that is high out of reset does not arm the interlock.
  always_comb
  begin
    next_state = state;
    unique case (state)
      PSPI_OFF:
      begin
        if (en_rise)
          next_state = PSPI_SETTLE;
      end
      PSPI_SETTLE:
      begin
        if (!I_EN_REQ)
          next_state = PSPI_OFF;
        else if (settle_cnt == SETTLE_CYCLES_P - 1)
          next_state = PSPI_RUN;
      end
      PSPI_RUN:
      begin
        if (!I_EN_REQ)
          next_state = PSPI_OFF;
      end
      default:
      begin
        next_state = PSPI_OFF;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      state <= PSPI_OFF;
    else
      state <= next_state;
  end

  // The count restarts on every entry, so a dropped request leaves no credit.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      settle_cnt <= 32'h0000_0000;
    else if (state == PSPI_SETTLE && next_state == PSPI_SETTLE)
      settle_cnt <= settle_cnt + 32'h0000_0001;
    else
      settle_cnt <= 32'h0000_0000;
  end

  // Without the interlock the outputs run free; trips still apply.
  assign next_run = ctrl[CTRL_PRESENT] ? (next_state == PSPI_RUN) : 1'b1;

  // Status and PWM gating load from the same term so they move together.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_STATUS <= 1'b0;
    else
      O_STATUS <= next_run;
  end

  // Registering the level costs one cycle but keeps the pin free of glitches.
  // The gate enable pin is a pure indicator and feeds nothing below.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_GATE_EN <= 1'b0;
    else
      O_GATE_EN <= (next_state != PSPI_OFF) ~^ ctrl[CTRL_POL_HIGH];
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_GATE_EN_OE <= 1'b0;
    else
      O_GATE_EN_OE <= ctrl[CTRL_GPIO_CFG];
  end

  assign trip.trip_n    = {I_TRIP_ZONE_INPUT_3_N, I_TRIP_ZONE_INPUT_2_N, I_TRIP_ZONE_INPUT_1_N};
  assign trip.ana       = I_ANALOG_TRIP;
  assign trip.underflow = I_PWM_UNDERFLOW;
  assign trip.rearm     = en_rise && state == PSPI_OFF;
  assign trip.dig_react = trip_cfg[TCFG_ANA_LSB-1:0];
  assign trip.ana_react = trip_cfg[TCFG_W-1:TCFG_ANA_LSB];

  pspi_trip_unit u_trip (
    .i_clk  (I_SYS_CLK),
    .i_rstn (I_RSTN),
    .trip   (trip)
  );

  assign tripped = |{trip.os_latch, trip.cbc_latch, trip.ana_latch};

  genvar g;

  generate
    for (g = 0; g < N_PWM; g++)
    begin : g_pwm
      // Off means driven passive; a trip may instead release the pin.
      always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
      begin
        if (!I_RSTN)
          O_PWM[g] <= 1'b0;
        else if (next_run && !tripped)
          O_PWM[g] <= I_PWM[g];
        else
          O_PWM[g] <= passive[g];
      end

      always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
      begin
        if (!I_RSTN)
          O_PWM_OE[g] <= 1'b1;
        else
          O_PWM_OE[g] <= !(tripped && ctrl[CTRL_SAFE_FLOAT]);
      end
    end
  endgenerate

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      ctrl <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl <= I_WDATA[CTRL_W-1:0];
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      trip_cfg <= TCFG_RESET;
    else if (wr_tcfg)
      trip_cfg <= I_WDATA[TCFG_W-1:0];
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      passive <= '0;
    else if (wr_pass)
      passive <= I_WDATA[N_PWM-1:0];
  end

  always_comb
  begin
    rd_value = '0;
    unique case (I_ADDR)
      ADDR_CTRL:
      begin
        rd_value[CTRL_W-1:0] = ctrl;
      end
      ADDR_TRIP_CFG:
      begin
        rd_value[TCFG_W-1:0] = trip_cfg;
      end
      ADDR_PASSIVE:
      begin
        rd_value[N_PWM-1:0] = passive;
      end
      ADDR_STATUS:
      begin
        rd_value[ST_RUN]                = O_STATUS;
        rd_value[ST_SETTLE]             = state == PSPI_SETTLE;
        rd_value[ST_OS_LSB +: N_DIG]    = trip.os_latch;
        rd_value[ST_CBC_LSB +: N_DIG]   = trip.cbc_latch;
        rd_value[ST_ANA_LSB +: N_ANA]   = trip.ana_latch;
      end
      default:
      begin
        rd_value = '0;
      end
    endcase
  end

  // Read data stand for as many cycles as I_RD was held high, one cycle later, and return to zero after.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_RDATA <= '0;
    else if (I_RD)
      O_RDATA <= rd_value;
    else
      O_RDATA <= '0;
  end

endmodule

// ---- verif/pspi_top_checker.sv ----
`timescale 1ns/10ps
module pspi_top_checker
  import pspi_pkg::*;
#(
  parameter int unsigned N_PWM           = 6,
  parameter int unsigned SETTLE_CYCLES_P = SETTLE_CYCLES
)
(
  input wire logic              I_SYS_CLK,
  input wire logic              I_RSTN,
  input wire logic              I_EN_REQ,
  input wire logic              I_TRIP_ZONE_INPUT_1_N,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic [DATA_W-1:0] I_WDATA,
  input wire logic              I_WR,
  input wire logic [N_PWM-1:0]  O_PWM,
  input wire logic [N_PWM-1:0]  O_PWM_OE,
  input wire logic              O_STATUS,
  input wire logic              O_GATE_EN
);
  logic [CTRL_W-1:0] ctl;
  logic [TCFG_W-1:0] tcfg;
  logic [N_PWM-1:0]  pas;
  logic              en_q;
  logic              arm_w;
  logic              safe_ok;
  logic [31:0]       since_arm;

  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);

  // Shadow copies of the settings, so every check knows the mode in force.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    if (!I_RSTN)
    begin
      ctl  <= CTRL_RESET;
      tcfg <= TCFG_RESET;
      pas  <= '0;
      en_q <= 1'b1;
    end
    else
    begin
      en_q <= I_EN_REQ;
      if (I_WR && I_ADDR == ADDR_CTRL)
        ctl <= I_WDATA[CTRL_W-1:0];
      if (I_WR && I_ADDR == ADDR_TRIP_CFG)
        tcfg <= I_WDATA[TCFG_W-1:0];
      if (I_WR && I_ADDR == ADDR_PASSIVE)
        pas <= I_WDATA[N_PWM-1:0];
    end

  assign arm_w   = ctl[CTRL_PRESENT] && I_EN_REQ && !en_q;
  assign safe_ok = ctl[CTRL_SAFE_FLOAT] ? (O_PWM_OE == '0) : (O_PWM == pas && &O_PWM_OE);

  // Cycles since the last arming edge; it saturates so a long run cannot wrap.
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN)
    if (!I_RSTN)
      since_arm <= '1;
    else if (arm_w)
      since_arm <= 32'h0000_0001;
    else if (since_arm != '1)
      since_arm <= since_arm + 32'h0000_0001;

  sequence arm_s;
    arm_w;
  endsequence

  gate_on_a: assert property (arm_s |=> O_GATE_EN == $past(ctl[CTRL_POL_HIGH]))
    else $error("gate level after request");
  gate_off_a: assert property (ctl[CTRL_PRESENT] && !I_EN_REQ |=> O_GATE_EN != $past(ctl[CTRL_POL_HIGH]))
    else $error("gate level when idle");
  status_off_a: assert property (ctl[CTRL_PRESENT] && !I_EN_REQ |=> !O_STATUS)
    else $error("status high when idle");
  settle_low_a: assert property (arm_s |=> !O_STATUS [*3])
    else $error("status early");
  status_rise_a: assert property (ctl[CTRL_PRESENT] && $rose(O_STATUS) |-> since_arm == SETTLE_CYCLES_P + 1)
    else $error("status rise time");
  absent_run_a: assert property (!ctl[CTRL_PRESENT] |=> O_STATUS)
    else $error("status low when absent");
  held_off_a: assert property ($past(ctl[CTRL_PRESENT]) && !$past(ctl[CTRL_SAFE_FLOAT]) && !O_STATUS |-> O_PWM == $past(pas) && &O_PWM_OE)
    else $error("pwm not passive");
  trip_safe_a: assert property (tcfg[1:0] == REACT_ONESHOT && !I_TRIP_ZONE_INPUT_1_N |-> ##2 safe_ok)
    else $error("pwm not safe");
endmodule

bind pspi_top pspi_top_checker #(.N_PWM(N_PWM), .SETTLE_CYCLES_P(SETTLE_CYCLES_P)) pspi_top_checker_i (
  .I_SYS_CLK, .I_RSTN, .I_EN_REQ, .I_TRIP_ZONE_INPUT_1_N, .I_ADDR, .I_WDATA, .I_WR,
  .O_PWM, .O_PWM_OE, .O_STATUS, .O_GATE_EN
);

// ---- verif/pspi_src_model.sv ----
`timescale 1ns/10ps
module pspi_src_model
#(
  parameter int unsigned UF_PERIOD = 8
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic [2:0] i_tz_fault,
  input  wire logic [2:0] i_ana_fault,
  output logic      [2:0] o_tz_n,
  output logic      [2:0] o_ana,
  output logic            o_uf
);
  logic [7:0] uf_cnt;

  // Faults are registered so a source never glitches between edges.
  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      o_tz_n <= 3'h7;
      o_ana  <= 3'h0;
    end
    else
    begin
      o_tz_n <= ~i_tz_fault;
      o_ana  <= i_ana_fault;
    end

  always_ff @(posedge i_clk or negedge i_rstn)
    if (!i_rstn)
    begin
      uf_cnt <= 8'h00;
      o_uf   <= 1'b0;
    end
    else
    begin
      o_uf   <= (uf_cnt == 8'(UF_PERIOD - 1));
      uf_cnt <= (uf_cnt == 8'(UF_PERIOD - 1)) ? 8'h00 : uf_cnt + 8'h01;
    end
endmodule

// ---- verif/tb_pspi_top.sv ----
`timescale 1ns/10ps
module tb_pspi_top
  import pspi_pkg::*;
();
  localparam int unsigned ST = 4;
  logic        clk = 0, rstn = 0, en = 1, wr = 0, rd = 0, uf, st_o, g_o, goe_o;
  logic [5:0]  pwm_r = '0, pas = '0, pwm_o, oe_o;
  logic [2:0]  tzf = '0, anaf = '0, tz_n, ana;
  logic [7:0]  addr = '0;
  logic [31:0] wdat = '0, rdat;
  int          errors = 0, compares = 0;
  bit          flt = 0;
  logic [7:0]  reg_acc = '0;

  always #25 clk = ~clk;

  // A stand-in regulator whose integrator is cleared while the interlock is not running.
  always @(posedge clk)
    reg_acc <= st_o ? reg_acc + 8'h01 : 8'h00;

  pspi_src_model pspi_src_model_i (.i_clk(clk), .i_rstn(rstn), .i_tz_fault(tzf),
    .i_ana_fault(anaf), .o_tz_n(tz_n), .o_ana(ana), .o_uf(uf));
  pspi_top #(.SETTLE_CYCLES_P(ST)) pspi_top_i (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_EN_REQ(en),
    .I_PWM(pwm_r), .I_PWM_UNDERFLOW(uf), .I_TRIP_ZONE_INPUT_1_N(tz_n[0]),
    .I_TRIP_ZONE_INPUT_2_N(tz_n[1]), .I_TRIP_ZONE_INPUT_3_N(tz_n[2]), .I_ANALOG_TRIP(ana),
    .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .O_PWM(pwm_o),
    .O_PWM_OE(oe_o), .O_STATUS(st_o), .O_GATE_EN(g_o), .O_GATE_EN_OE(goe_o));

  task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, exp, got);
    end
  endtask

  task final_report;
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1; addr <= a; wdat <= d;
    @(posedge clk);
    wr <= 0;
  endtask

  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1; addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk("rdata", rdat, e);
  endtask

  task arm;
    en <= 0;
    cyc(2);
    en <= 1;
    cyc(ST + 3);
  endtask

  task look(input bit safe);
    if (safe && flt)
      chk("oe", oe_o, 6'h00);
    else
    begin
      chk("oe", oe_o, 6'h3F);
      chk("pwm", pwm_o, safe ? pas : pwm_r);
    end
  endtask

  function automatic logic [31:0] exp_status(input int k, input int m);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[ST_RUN] = 1'b1;
    if (k < 3 && m == 1)
      v[ST_OS_LSB + k] = 1'b1;
    else if (k < 3 && m == 2)
      v[ST_CBC_LSB + k] = 1'b1;
    else if (k >= 3 && m == 1)
      v[ST_ANA_LSB + k - 3] = 1'b1;
    return v;
  endfunction

  initial
  begin
    void'($urandom(20546));
    pwm_r = 6'($urandom);
    pas = 6'($urandom);
    repeat (6) @(posedge clk);
    rstn <= 1;
    cyc(8);
    chk("status", st_o, 0);
    rd_chk(ADDR_CTRL, 32'h5);
    rd_chk(8'h10, 32'h0);
    wr_reg(ADDR_PASSIVE, {26'h0, pas});
    rd_chk(ADDR_PASSIVE, {26'h0, pas});
    for (int p = 0; p < 2; p++)
    begin
      wr_reg(ADDR_CTRL, p ? 32'h7 : 32'h3);
      en <= 0;
      cyc(2);
      chk("gate", g_o, !p);
      chk("gate oe", goe_o, 1);
      en <= 1;
      cyc(2);
      chk("gate", g_o, p);
      cyc(ST - 2);
      chk("status", st_o, 0);
      pwm_r <= 6'($urandom);
      cyc(1);
      chk("status", st_o, 1);
      look(0);
      en <= 0;
      cyc(2);
      chk("status", st_o, 0);
      look(1);
      chk("regulator", reg_acc, 8'h00);
    end
    for (int k = 0; k < 6; k++)
      for (int m = 0; m < 3; m++)
      begin
        if (k > 2 && m == 2)
          continue;
        flt = k[0];
        wr_reg(ADDR_CTRL, flt ? 32'hD : 32'h5);
        wr_reg(ADDR_TRIP_CFG, k < 3 ? m << (2 * k) : m << (3 + k));
        arm;
        look(0);
        if (k < 3)
          tzf[k] <= 1;
        else
          anaf[k - 3] <= 1;
        cyc(12);
        look(m != 0);
        rd_chk(ADDR_STATUS, exp_status(k, m));
        tzf <= 0;
        anaf <= 0;
        cyc(12);
        look(m == 1);
        arm;
        look(0);
      end
    wr_reg(ADDR_CTRL, 32'h0);
    en <= 0;
    cyc(3);
    chk("status", st_o, 1);
    rd_chk(ADDR_STATUS, 32'h1);
    final_report;
  end

  initial
  begin
    repeat (6000) @(posedge clk);
    errors++;
    final_report;
  end
endmodule
